//--- rtl/tpi_top.sv
// timer prescaler, edge select, interval and pulse modes for two 16-bit channels
// registers written over an 8-bit memory port; timer pins and watch pulse are asynchronous
`timescale 1ns/10ps
`include "tpi_params.svh"

// How it works
// - reset clears all prescaler registers to zero
// - timer0 pin1 edge select in bits 7:6
// - timer0 pin0 edge select in bits 5:4
// - timer0 three-bit count clock source table
// - timer1 three-bit count clock source table
// - timer1 pin0 edge select same coding
// - first start after reset with high pin rises
// - interval match clears counter and raises irq
// - pulse mode drives periodic pulse on output
// - period compare0+1, width compare1+1 count clocks
// - edge needs new level sampled twice
// - output enable low forces output pin low
module tpi_top
	import tpi_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic [31:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic timer0_input_pin0_in,
	input wire logic timer0_input_pin1_in,
	input wire logic timer1_input_pin0_in,
	input wire logic watch_timer_irq_in,
	input wire logic [3:0] timer_mode_control_in,
	input wire logic [1:0] timer_output_enable_in,
	input wire logic [2*CNT_W-1:0] compare_reg_zero_in,
	input wire logic [2*CNT_W-1:0] compare_reg_one_in,
	output logic [CNT_W-1:0] timer0_counter_out,
	output logic [CNT_W-1:0] timer1_counter_out,
	output logic [1:0] compare_zero_irq_out,
	output logic [1:0] timer_output_pin_out,
	output logic [2:0] valid_edge_out
);
	logic [7:0] sel_q [2];
	logic [7:0] sel_d [2];
	logic [7:0] hi_q [2];
	logic [7:0] hi_d [2];
	logic [7:0] rdata_d;
	logic [2:0] pin_s1_q, pin_s2_q, edge_hit, edge_q;
	logic [2:0] wt_q, wt_d;
	logic wt_pulse;
	logic [`TPI_DIV_W-1:0] div_q, div_d, div_tick;
	logic [2:0] code [2];
	logic [1:0] cnt_tick, run, samp;
	logic [CNT_W-1:0] cnt_q [2];
	logic [CNT_W-1:0] cnt_d [2];
	logic [1:0] irq_q, irq_d, out_q, out_d;
	tpi_edge_sel_t pin_sel [3];

	// register port: writes drop fixed-zero bits, unmapped reads return zero
	always_comb begin
		sel_d = sel_q;
		hi_d = hi_q;
		rdata_d = `TPI_REG_RESET;
		if (reg_wr_in) begin
			case (reg_addr_in)
				`TPI_ADDR_T0_SEL: sel_d[0] = reg_wdata_in & `TPI_SEL_MASK;
				`TPI_ADDR_T0_HI: hi_d[0] = reg_wdata_in & `TPI_HI_MASK;
				`TPI_ADDR_T1_SEL: sel_d[1] = reg_wdata_in & `TPI_SEL_MASK;
				`TPI_ADDR_T1_HI: hi_d[1] = reg_wdata_in & `TPI_HI_MASK;
				default: ;
			endcase
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				`TPI_ADDR_T0_SEL: rdata_d = sel_q[0];
				`TPI_ADDR_T0_HI: rdata_d = hi_q[0];
				`TPI_ADDR_T1_SEL: rdata_d = sel_q[1];
				`TPI_ADDR_T1_HI: rdata_d = hi_q[1];
				default: rdata_d = `TPI_REG_RESET;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			sel_q <= '{`TPI_REG_RESET, `TPI_REG_RESET};
			hi_q <= '{`TPI_REG_RESET, `TPI_REG_RESET};
			reg_rdata_out <= `TPI_REG_RESET;
		end else begin
			sel_q <= sel_d;
			hi_q <= hi_d;
			reg_rdata_out <= rdata_d;
		end
	end

	// pin synchronisers and watch pulse edge
	assign wt_d = {wt_q[1:0], watch_timer_irq_in};
	assign wt_pulse = wt_q[1] && !wt_q[2];

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
			wt_q <= 3'h0;
		end else begin
			pin_s1_q <= {timer1_input_pin0_in, timer0_input_pin1_in, timer0_input_pin0_in};
			pin_s2_q <= pin_s1_q;
			wt_q <= wt_d;
		end
	end

	// free-running prescaler; bit k-1 tick = main clock divided by 2^k
	assign div_d = div_q + `TPI_DIV_W'(1);
	genvar gk;
	generate
		for (gk = 0; gk < `TPI_DIV_W; gk++) begin : g_div
			assign div_tick[gk] = &div_q[gk:0];
		end
	endgenerate

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	// edge detectors: timer0 pin0, timer0 pin1, timer1 pin0
	assign pin_sel[`TPI_PIN_T0_IN0] = tpi_edge_sel_t'(sel_q[0][`TPI_IN0_EDGE_HI:`TPI_IN0_EDGE_LO]);
	assign pin_sel[`TPI_PIN_T0_IN1] = tpi_edge_sel_t'(sel_q[0][`TPI_IN1_EDGE_HI:`TPI_IN1_EDGE_LO]);
	assign pin_sel[`TPI_PIN_T1_IN0] = tpi_edge_sel_t'(sel_q[1][`TPI_IN0_EDGE_HI:`TPI_IN0_EDGE_LO]);

	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_pin
			localparam int CH = (gp == `TPI_PIN_T1_IN0) ? 1 : 0;
			tpi_edge_if eif ();
			assign eif.sample = samp[CH];
			assign eif.pin = pin_s2_q[gp];
			assign eif.sel = pin_sel[gp];
			assign eif.run = run[CH];
			assign edge_hit[gp] = eif.edge_hit;
			tpi_edge_det u_det (
				.clk_sys_in(clk_sys_in),
				.rst_b_in(rst_b_in),
				.port_if(eif.det)
			);
		end
	endgenerate

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			edge_q <= 3'h0;
		end else begin
			edge_q <= edge_hit;
		end
	end
	assign valid_edge_out = edge_q;

	// channels: count clock selection, counter, compare match, pulse output
	genvar gc;
	generate
		for (gc = 0; gc < 2; gc++) begin : g_ch
			localparam int EXT = (gc == 0) ? `TPI_PIN_T0_IN0 : `TPI_PIN_T1_IN0;
			tpi_mode_t mode;
			logic [CNT_W-1:0] cr0, cr1;
			logic hit0;
			assign mode = tpi_mode_t'(timer_mode_control_in[2*gc+:2]);
			assign cr0 = compare_reg_zero_in[CNT_W*gc+:CNT_W];
			assign cr1 = compare_reg_one_in[CNT_W*gc+:CNT_W];
			assign code[gc] = {hi_q[gc][`TPI_CLKSEL_BIT2],
				sel_q[gc][`TPI_CLKSEL_HI:`TPI_CLKSEL_LO]};
			assign run[gc] = (mode == TPI_MODE_INTERVAL) || (mode == TPI_MODE_PULSE);
			// an external edge is sampled at main/2, internal ones at the count clock
			assign samp[gc] = (code[gc] == `TPI_CK_EXT) ? div_tick[`TPI_DIV2] : cnt_tick[gc];
			assign hit0 = cnt_q[gc] == cr0;

			always_comb begin
				cnt_tick[gc] = 1'b0;
				case (code[gc])
					`TPI_CK_0: cnt_tick[gc] = div_tick[`TPI_DIV2];
					`TPI_CK_1: cnt_tick[gc] = (gc == 0) ? div_tick[`TPI_DIV16] : div_tick[`TPI_DIV4];
					`TPI_CK_2: cnt_tick[gc] = (gc == 0) ? wt_pulse : div_tick[`TPI_DIV16];
					`TPI_CK_EXT: cnt_tick[gc] = edge_q[EXT];
					`TPI_CK_4: cnt_tick[gc] = (gc == 0) ? div_tick[`TPI_DIV4] : div_tick[`TPI_DIV32];
					`TPI_CK_5: cnt_tick[gc] = (gc == 0) ? div_tick[`TPI_DIV64] : div_tick[`TPI_DIV128];
					`TPI_CK_6: cnt_tick[gc] = div_tick[`TPI_DIV256];
					default: cnt_tick[gc] = 1'b0;
				endcase
			end

			always_comb begin
				cnt_d[gc] = cnt_q[gc];
				irq_d[gc] = 1'b0;
				if (!run[gc]) begin
					cnt_d[gc] = '0;
				end else if (cnt_tick[gc]) begin
					if (hit0) begin
						cnt_d[gc] = '0;
						irq_d[gc] = 1'b1;
					end else begin
						cnt_d[gc] = cnt_q[gc] + CNT_W'(1);
					end
				end
				// high for counts 0..cr1, period cr0+1
				out_d[gc] = timer_output_enable_in[gc] && (mode == TPI_MODE_PULSE)
					&& (cnt_d[gc] <= cr1);
			end

			always_ff @(posedge clk_sys_in) begin
				if (!rst_b_in) begin
					cnt_q[gc] <= '0;
					irq_q[gc] <= 1'b0;
					out_q[gc] <= 1'b0;
				end else begin
					cnt_q[gc] <= cnt_d[gc];
					irq_q[gc] <= irq_d[gc];
					out_q[gc] <= out_d[gc];
				end
			end

			property p_interval_match;
				run[gc] && cnt_tick[gc] && hit0 |=> cnt_q[gc] == '0 && irq_q[gc];
			endproperty
			a_interval_match: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
				p_interval_match) else $error("match did not clear and interrupt");

			sequence s_width_end;
				mode == TPI_MODE_PULSE && timer_output_enable_in[gc] && cnt_tick[gc]
					&& cnt_q[gc] == cr1 && cr1 < cr0;
			endsequence
			property p_pulse_width;
				s_width_end |=> !out_q[gc];
			endproperty
			a_pulse_width: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
				p_pulse_width) else $error("pulse width wrong");

			property p_period_start;
				mode == TPI_MODE_PULSE && timer_output_enable_in[gc] && cnt_tick[gc] && hit0
					|=> out_q[gc];
			endproperty
			a_period_start: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
				p_period_start) else $error("pulse period wrong");

			property p_oe_low;
				!timer_output_enable_in[gc] |=> !out_q[gc];
			endproperty
			a_oe_low: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
				p_oe_low) else $error("output not held low");

			property p_prohibited_clock;
				run[gc] && code[gc] == `TPI_CK_PROH |=> $stable(cnt_q[gc]);
			endproperty
			a_prohibited_clock: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
				p_prohibited_clock) else $error("count on prohibited clock");

			property p_div2_rate;
				run[gc] && code[gc] == `TPI_CK_0 && $changed(cnt_q[gc]) |=> $stable(cnt_q[gc]);
			endproperty
			a_div2_rate: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
				p_div2_rate) else $error("main/2 rate exceeded");
		end
	endgenerate

	assign timer0_counter_out = cnt_q[0];
	assign timer1_counter_out = cnt_q[1];
	assign compare_zero_irq_out = irq_q;
	assign timer_output_pin_out = out_q;

	property p_reset_clear;
		@(posedge clk_sys_in) !rst_b_in |=> sel_q[0] == `TPI_REG_RESET && hi_q[1] == `TPI_REG_RESET;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear registers");

	property p_fixed_zero;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		hi_q[0][7:1] == 7'h00 && sel_q[1][3:2] == 2'h0;
	endproperty
	a_fixed_zero: assert property (p_fixed_zero) else $error("fixed bits not zero");

	property p_watch_step;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		wt_pulse && code[0] == `TPI_CK_2 && run[0] && cnt_q[0] != compare_reg_zero_in[CNT_W-1:0]
			|=> cnt_q[0] == $past(cnt_q[0]) + CNT_W'(1);
	endproperty
	a_watch_step: assert property (p_watch_step) else $error("watch pulse not counted");
endmodule : tpi_top

//--- rtl/tpi_params.svh
// register addresses, field positions, reset values and select codes of the timer prescaler
// assumes an 8-bit register port decoded on full 32-bit byte addresses
`ifndef TPI_PARAMS_SVH
`define TPI_PARAMS_SVH

`define TPI_ADDR_T0_SEL 32'hFFFFF206
`define TPI_ADDR_T0_HI 32'hFFFFF20E
`define TPI_ADDR_T1_SEL 32'hFFFFF216
`define TPI_ADDR_T1_HI 32'hFFFFF21E

`define TPI_REG_RESET 8'h00
`define TPI_SEL_MASK 8'hF3
`define TPI_HI_MASK 8'h01

`define TPI_IN1_EDGE_HI 7
`define TPI_IN1_EDGE_LO 6
`define TPI_IN0_EDGE_HI 5
`define TPI_IN0_EDGE_LO 4
`define TPI_CLKSEL_HI 1
`define TPI_CLKSEL_LO 0
`define TPI_CLKSEL_BIT2 0

`define TPI_CK_0 3'h0
`define TPI_CK_1 3'h1
`define TPI_CK_2 3'h2
`define TPI_CK_EXT 3'h3
`define TPI_CK_4 3'h4
`define TPI_CK_5 3'h5
`define TPI_CK_6 3'h6
`define TPI_CK_PROH 3'h7

`define TPI_DIV_W 8
`define TPI_DIV2 0
`define TPI_DIV4 1
`define TPI_DIV16 3
`define TPI_DIV32 4
`define TPI_DIV64 5
`define TPI_DIV128 6
`define TPI_DIV256 7

`define TPI_PIN_T0_IN0 0
`define TPI_PIN_T0_IN1 1
`define TPI_PIN_T1_IN0 2

`endif

//--- rtl/tpi_pkg.sv
// types shared by the timer prescaler design
// no dependencies
package tpi_pkg;
	typedef enum logic [1:0] {
		TPI_EDGE_FALL = 2'h0,
		TPI_EDGE_RISE = 2'h1,
		TPI_EDGE_PROH = 2'h2,
		TPI_EDGE_BOTH = 2'h3
	} tpi_edge_sel_t;

	typedef enum logic [1:0] {
		TPI_MODE_STOP = 2'h0,
		TPI_MODE_INTERVAL = 2'h1,
		TPI_MODE_PULSE = 2'h2,
		TPI_MODE_RSVD = 2'h3
	} tpi_mode_t;
endpackage : tpi_pkg

//--- rtl/tpi_edge_if.sv
// carrier between the top and one valid-edge detector
// all signals are on clk_sys_in
`timescale 1ns/10ps
interface tpi_edge_if;
	import tpi_pkg::*;
	logic sample;
	logic pin;
	tpi_edge_sel_t sel;
	logic run;
	logic edge_hit;
	modport det (input sample, input pin, input sel, input run, output edge_hit);
	modport ctl (output sample, output pin, output sel, output run, input edge_hit);
endinterface : tpi_edge_if

//--- rtl/tpi_edge_det.sv
// valid-edge detector for one timer input pin, two-sample noise filter
// pin already synchronised; sample is a one-cycle strobe at the sampling rate
`timescale 1ns/10ps
module tpi_edge_det
	import tpi_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	tpi_edge_if.det port_if
);
	logic samp_q, samp_d, lvl_q, lvl_d, fresh_q, fresh_d, edge_q, edge_d;
	logic rise, fall, rise_ok, fall_ok;

	assign rise_ok = (port_if.sel == TPI_EDGE_RISE) || (port_if.sel == TPI_EDGE_BOTH);
	assign fall_ok = (port_if.sel == TPI_EDGE_FALL) || (port_if.sel == TPI_EDGE_BOTH);
	assign port_if.edge_hit = edge_q;

	always_comb begin
		samp_d = samp_q;
		lvl_d = lvl_q;
		fresh_d = fresh_q;
		rise = 1'b0;
		fall = 1'b0;
		if (port_if.sample) begin
			samp_d = port_if.pin;
			// level accepted only when seen on two samples in a row
			if ((port_if.pin == samp_q) && (port_if.pin != lvl_q)) begin
				lvl_d = port_if.pin;
				rise = port_if.pin;
				fall = !port_if.pin;
			end
		end
		if (port_if.run) begin
			fresh_d = 1'b0;
		end
		// first start after reset with the pin already high counts as a rise
		edge_d = port_if.run && ((rise && rise_ok) || (fall && fall_ok)
			|| (fresh_q && lvl_q && rise_ok));
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			samp_q <= 1'b0;
			lvl_q <= 1'b0;
			fresh_q <= 1'b1;
			edge_q <= 1'b0;
		end else begin
			samp_q <= samp_d;
			lvl_q <= lvl_d;
			fresh_q <= fresh_d;
			edge_q <= edge_d;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);

	property p_edge_prohibited;
		port_if.sel == TPI_EDGE_PROH |=> !edge_q;
	endproperty
	a_edge_prohibited: assert property (p_edge_prohibited) else $error("edge on prohibited code");

	property p_first_start;
		fresh_q && lvl_q && port_if.run && rise_ok |=> edge_q ##1 !fresh_q;
	endproperty
	a_first_start: assert property (p_first_start) else $error("first start rise missed");

	property p_filter;
		edge_q && !$past(fresh_q) |-> $past(port_if.sample) && $past(port_if.pin) == $past(samp_q);
	endproperty
	a_filter: assert property (p_filter) else $error("edge without two equal samples");
endmodule : tpi_edge_det

//--- verif/tpi_pin_model.sv
// model of the three timer input pins outside the device
// assumes the bench's clock; a level change is held at least MIN_HOLD cycles
`timescale 1ns/10ps
module tpi_pin_model #(
	parameter int MIN_HOLD = 6,
	parameter logic [2:0] INIT = 3'h0
) (
	input wire logic clk_sys_in,
	input wire logic [2:0] level_req_in,
	input wire logic [2:0] noise_in,
	output logic [2:0] pin_out
);
	logic [2:0] held_q = INIT;
	int hold_q[3] = '{MIN_HOLD, MIN_HOLD, MIN_HOLD};

	always @(posedge clk_sys_in) begin
		for (int i = 0; i < 3; i++) begin
			if (level_req_in[i] != held_q[i] && hold_q[i] >= MIN_HOLD) begin
				held_q[i] <= level_req_in[i];
				hold_q[i] <= 0;
			end else if (hold_q[i] < MIN_HOLD) begin
				hold_q[i] <= hold_q[i] + 1;
			end
		end
	end

	// noise lets a scenario inject a glitch shorter than the hold
	assign pin_out = held_q ^ noise_in;
endmodule : tpi_pin_model

//--- verif/tpi_top_test.sv
// self-checking bench for the timer prescaler, interval and pulse modes
// assumes the pin model beside the device and a 50 MHz clock
`timescale 1ns/10ps
`include "tpi_params.svh"
module tpi_top_test;
	import tpi_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [31:0] addr = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [2:0] pins;
	logic [2:0] level_req = 3'h1;
	logic [2:0] noise = 3'h0;
	logic watch_in = 1'b0;
	logic [3:0] mode_in = 4'h0;
	logic [1:0] oe_in = 2'h3;
	logic [31:0] cr0_in = 32'hFFFFFFFF;
	logic [31:0] cr1_in = 32'h0;
	logic [15:0] cnt0;
	logic [15:0] cnt1;
	logic [1:0] irq;
	logic [1:0] pulse;
	logic [2:0] valid_edge;
	logic [3:0] obs;
	int ve_cnt[3] = '{0, 0, 0};
	int bad_count = 0;
	int num_checks = 0;
	int n;
	int w;

	always #10 clk_sys_in = ~clk_sys_in;
	assign obs = {pulse, irq};

	tpi_pin_model #(.MIN_HOLD(6), .INIT(3'h1)) partner (.clk_sys_in(clk_sys_in),
		.level_req_in(level_req), .noise_in(noise), .pin_out(pins));

	tpi_top #(.CNT_W(16)) uut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .timer0_input_pin0_in(pins[0]), .timer0_input_pin1_in(pins[1]),
		.timer1_input_pin0_in(pins[2]), .watch_timer_irq_in(watch_in),
		.timer_mode_control_in(mode_in), .timer_output_enable_in(oe_in),
		.compare_reg_zero_in(cr0_in), .compare_reg_one_in(cr1_in),
		.timer0_counter_out(cnt0), .timer1_counter_out(cnt1), .compare_zero_irq_out(irq),
		.timer_output_pin_out(pulse), .valid_edge_out(valid_edge));

	always @(posedge clk_sys_in) begin
		for (int i = 0; i < 3; i++) begin
			if (valid_edge[i] === 1'b1) begin
				ve_cnt[i] <= ve_cnt[i] + 1;
			end
		end
	end

	task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic close_out;
		if (bad_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys_in);
	endtask : cyc

	task automatic reg_wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [31:0] a, input logic [7:0] exp, input string name);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		#1;
		check(name, {8'h00, rdata}, {8'h00, exp});
	endtask : reg_rd

	// counts cycles until the watched output reaches v, gives up at 2000
	task automatic wait_sig(input int idx, input logic v, output int k);
		k = 0;
		do begin
			@(posedge clk_sys_in);
			#1;
			k++;
		end while (obs[idx] !== v && k < 2000);
	endtask : wait_sig

	task automatic set_ch(input int ch, input logic [7:0] sel, input logic [7:0] hi,
		input tpi_mode_t md, input logic [15:0] c0, input logic [15:0] c1);
		@(posedge clk_sys_in);
		mode_in[ch*2 +: 2] <= TPI_MODE_STOP;
		reg_wr(ch ? `TPI_ADDR_T1_SEL : `TPI_ADDR_T0_SEL, sel);
		reg_wr(ch ? `TPI_ADDR_T1_HI : `TPI_ADDR_T0_HI, hi);
		@(posedge clk_sys_in);
		cr0_in[ch*16 +: 16] <= c0;
		cr1_in[ch*16 +: 16] <= c1;
		mode_in[ch*2 +: 2] <= md;
	endtask : set_ch

	task automatic toggle(input int p, input int k);
		repeat (k) begin
			@(posedge clk_sys_in);
			level_req[p] <= ~level_req[p];
			cyc(12);
		end
		cyc(4);
	endtask : toggle

	task automatic t_regs;
		reg_rd(`TPI_ADDR_T0_SEL, 8'h00, "t0 select");
		reg_rd(`TPI_ADDR_T0_HI, 8'h00, "t0 high");
		reg_rd(`TPI_ADDR_T1_SEL, 8'h00, "t1 select");
		reg_rd(`TPI_ADDR_T1_HI, 8'h00, "t1 high");
		reg_wr(`TPI_ADDR_T1_SEL, 8'hFF);
		reg_wr(`TPI_ADDR_T1_HI, 8'hFF);
		reg_wr(32'hFFFFF208, 8'hFF);
		reg_rd(`TPI_ADDR_T1_SEL, 8'hF3, "t1 select mask");
		reg_rd(`TPI_ADDR_T1_HI, 8'h01, "t1 high mask");
		reg_rd(32'hFFFFF208, 8'h00, "unmapped");
		reg_wr(`TPI_ADDR_T1_SEL, 8'h00);
		reg_wr(`TPI_ADDR_T1_HI, 8'h00);
	endtask : t_regs

	task automatic t_reset;
		reg_wr(`TPI_ADDR_T0_SEL, 8'hF3);
		reg_wr(`TPI_ADDR_T0_HI, 8'h01);
		rst_b_in <= 1'b0;
		cyc(2);
		rst_b_in <= 1'b1;
		reg_rd(`TPI_ADDR_T0_SEL, 8'h00, "t0 select reset");
		reg_rd(`TPI_ADDR_T0_HI, 8'h00, "t0 high reset");
	endtask : t_reset

	task automatic t_first_start;
		n = ve_cnt[0];
		set_ch(0, 8'h10, 8'h00, TPI_MODE_INTERVAL, 16'hFFFF, 16'h0);
		cyc(20);
		check("first start edge", 16'(ve_cnt[0] - n), 16'h1);
		set_ch(0, 8'h10, 8'h00, TPI_MODE_STOP, 16'hFFFF, 16'h0);
		cyc(10);
		set_ch(0, 8'h10, 8'h00, TPI_MODE_INTERVAL, 16'hFFFF, 16'h0);
		cyc(20);
		check("restart edge", 16'(ve_cnt[0] - n), 16'h1);
		mode_in <= 4'h0;
		level_req <= 3'h0;
		cyc(20);
	endtask : t_first_start

	task automatic t_clk_codes;
		int div0[7] = '{2, 16, 0, 0, 4, 64, 256};
		int div1[7] = '{2, 4, 16, 0, 32, 128, 256};
		int d;
		for (int ch = 0; ch < 2; ch++) begin
			for (int c = 0; c < 7; c++) begin
				d = ch ? div1[c] : div0[c];
				if (d != 0) begin
					set_ch(ch, 8'(c & 3), 8'(c >> 2), TPI_MODE_INTERVAL, 16'h1, 16'h0);
					wait_sig(ch, 1'b1, n);
					check("count at match", ch ? cnt1 : cnt0, 16'h0);
					wait_sig(ch, 1'b1, n);
					check("match period", 16'(n), 16'(2 * d));
				end
			end
		end
		set_ch(0, 8'h03, 8'h01, TPI_MODE_INTERVAL, 16'h0, 16'h0);
		wait_sig(0, 1'b1, n);
		check("code 7 silent", 16'(n), 16'd2000);
	endtask : t_clk_codes

	task automatic t_watch;
		set_ch(0, 8'h02, 8'h00, TPI_MODE_INTERVAL, 16'hFFFF, 16'h0);
		repeat (5) begin
			@(posedge clk_sys_in);
			watch_in <= 1'b1;
			cyc(3);
			watch_in <= 1'b0;
			cyc(3);
		end
		cyc(6);
		check("watch ticks", cnt0, 16'h5);
	endtask : t_watch

	task automatic t_ext;
		set_ch(0, 8'h13, 8'h00, TPI_MODE_INTERVAL, 16'hFFFF, 16'h0);
		toggle(0, 8);
		check("t0 external count", cnt0, 16'h4);
		set_ch(1, 8'h33, 8'h00, TPI_MODE_INTERVAL, 16'hFFFF, 16'h0);
		toggle(2, 8);
		check("t1 external count", cnt1, 16'h8);
	endtask : t_ext

	task automatic t_edges;
		int exp[4] = '{2, 2, 0, 4};
		for (int p = 0; p < 3; p++) begin
			for (int e = 0; e < 4; e++) begin
				set_ch(p / 2, (p == 1) ? 8'(e << 6) : 8'(e << 4), 8'h00, TPI_MODE_INTERVAL,
					16'hFFFF, 16'h0);
				n = ve_cnt[p];
				toggle(p, 4);
				check("edge count", 16'(ve_cnt[p] - n), 16'(exp[e]));
			end
		end
		set_ch(0, 8'h30, 8'h00, TPI_MODE_INTERVAL, 16'hFFFF, 16'h0);
		n = ve_cnt[0];
		@(posedge clk_sys_in);
		noise[0] <= 1'b1;
		// two cycles wide: exactly one main/2 sample sees it
		cyc(2);
		noise[0] <= 1'b0;
		cyc(16);
		check("glitch", 16'(ve_cnt[0] - n), 16'h0);
	endtask : t_edges

	task automatic t_pulse;
		for (int ch = 0; ch < 2; ch++) begin
			set_ch(ch, 8'h00, 8'h00, TPI_MODE_PULSE, 16'h5, 16'h2);
			// the first pulse after start is cut short by the prescaler phase; skip it
			wait_sig(2 + ch, 1'b0, w);
			wait_sig(2 + ch, 1'b1, n);
			wait_sig(2 + ch, 1'b0, w);
			check("pulse width", 16'(w), 16'd6);
			wait_sig(2 + ch, 1'b1, n);
			check("pulse period", 16'(w + n), 16'd12);
			@(posedge clk_sys_in);
			oe_in[ch] <= 1'b0;
			cyc(2);
			wait_sig(2 + ch, 1'b1, n);
			check("disabled output", 16'(n), 16'd2000);
			@(posedge clk_sys_in);
			oe_in[ch] <= 1'b1;
		end
	endtask : t_pulse

	initial begin
		cyc(10);
		rst_b_in <= 1'b1;
		cyc(2);
		t_regs();
		t_reset();
		t_first_start();
		t_clk_codes();
		t_watch();
		t_ext();
		t_edges();
		t_pulse();
		close_out();
	end

	initial begin
		cyc(40000);
		bad_count++;
		close_out();
	end
endmodule : tpi_top_test
